// [common/dio_port_pkg.sv]
`default_nettype none
package dio_port_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_GPO      = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_CMD      = 8'h14;
  localparam logic [7:0] OFF_INPUTS   = 8'h18;
  // reset values
  localparam logic [7:0] FILT_MS_RST  = 8'h09;
  localparam logic [4:0] GPO_RST      = 5'h00;
  localparam logic [5:0] IRQ_MASK_RST = 6'h00;
  // command bits
  localparam int CMD_OK    = 0;
  localparam int CMD_FAIL  = 1;
  localparam int CMD_CLEAR = 2;
  // event bits
  localparam int EV_START = 0;
  localparam int EV_STEP  = 1;
  localparam int EV_KEY1  = 2;
  localparam int EV_KEY2  = 3;
  localparam int EV_CLEAR = 4;
  localparam int EV_DONE  = 5;
  localparam int EV_W     = 6;
  // status fields
  localparam int ST_RUN_BIT  = 0;
  localparam int ST_PASS_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_STEP_BIT = 3;
  localparam int ST_SRC_LSB  = 4;
  localparam int ST_CODE_LSB = 8;
  // inputs register fields
  localparam int IN_SEL_LSB  = 8;
  localparam int IN_STEP_BIT = 16;
  localparam int IN_START_BIT = 17;
  localparam int IN_CLR_BIT  = 18;
  localparam int IN_PIN_LSB  = 19;
  // run sources
  localparam logic [1:0] SRC_START = 2'h0;
  localparam logic [1:0] SRC_STEP  = 2'h1;
  localparam logic [1:0] SRC_KEY1  = 2'h2;
  localparam logic [1:0] SRC_KEY2  = 2'h3;
  localparam logic [7:0] NO_SCRIPT = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS    = 8;
  localparam int MS_NS            = 1000000;
  localparam int MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
  localparam int KEY_MIN_WIDTH_MS = 30;
  localparam int KEY_MAX_WIDTH_MS = 200;
  localparam int KEY_MIN_GAP_MS   = 30;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } run_state_e;
endpackage
`default_nettype wire

// [hdl/dio_filter.sv]
`timescale 1ns/1ns
`default_nettype none
module dio_filter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ms_tick,
  input  wire logic [8:0] limit_ms,
  input  wire logic       raw,
  output logic            filt_ff
);
  logic [8:0] cnt_ff;
  logic [8:0] nxt_cnt;
  logic       nxt_filt;

  // level must stand limit_ms ticks before it is taken
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_filt = filt_ff;
    if (raw == filt_ff) begin
      nxt_cnt = 9'h000;
    end else if (ms_tick) begin
      if (cnt_ff + 9'h001 >= limit_ms) begin
        nxt_filt = raw;
        nxt_cnt  = 9'h000;
      end else begin
        nxt_cnt = cnt_ff + 9'h001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= 9'h000;
      filt_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      filt_ff <= nxt_filt;
    end
  end
endmodule
`default_nettype wire

// [hdl/dio_control_port.sv]
// What this block does
// - success pin pulled low after normal end
// - failure pin pulled low after abnormal end
// - running pin pulled low while run active
// - eight select inputs form script code
// - codes 1 to 255 name scripts
// - start edge latches code, loads script
// - step edge requests one-step execution
// - clear input resets run state, status
// - select, general, start and step inputs filtered by 1 to 256 ms
// - five general outputs set by software
// - five filtered general inputs readable
// - accepted aux key runs its sequence
`timescale 1ns/1ns
`default_nettype none
module dio_control_port #(
  parameter int unsigned MS_CYCLES = dio_port_pkg::MS_CYCLES
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic [7:0] script_select_in,
  input  wire logic [4:0] general_input,
  input  wire logic       step_input,
  input  wire logic       start_input,
  input  wire logic       user_clear_input,
  input  wire logic       aux_key_one_input,
  input  wire logic       aux_key_two_input,
  output logic [4:0]      general_output,
  input  wire logic       success_pin_in,
  output logic            success_pin_out,
  output logic            success_pin_oe_n,
  input  wire logic       failure_pin_in,
  output logic            failure_pin_out,
  output logic            failure_pin_oe_n,
  input  wire logic       running_pin_in,
  output logic            running_pin_out,
  output logic            running_pin_oe_n,
  output logic            irq
);
  localparam int DIV_W = $clog2(MS_CYCLES);
  localparam int FN = 15;

  if (MS_CYCLES < 2) begin : g_chk
    $error("MS_CYCLES must be at least 2");
  end

  // millisecond enable
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic             ms_tick;
  assign ms_tick = (div_ff == DIV_W'(MS_CYCLES - 1));
  always_comb nxt_div = ms_tick ? '0 : div_ff + DIV_W'(1);
  always_ff @(posedge aclk) begin
    if (!aresetn) div_ff <= '0;
    else          div_ff <= nxt_div;
  end

  // input filters, one per filtered line
  logic [7:0]    filt_ms_ff;
  logic [FN-1:0] raw_in, filt;
  logic [8:0]    limit_ms;
  assign raw_in   = {start_input, step_input, general_input, script_select_in};
  assign limit_ms = {1'b0, filt_ms_ff} + 9'h001;
  for (genvar i = 0; i < FN; i++) begin : g_filt
    dio_filter u_filt (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ms_tick  (ms_tick),
      .limit_ms (limit_ms),
      .raw      (raw_in[i]),
      .filt_ff  (filt[i])
    );
  end
  logic [7:0] sel_f;
  logic [4:0] gpi_f;
  assign sel_f = filt[7:0];
  assign gpi_f = filt[12:8];

  // edge detection on filtered start, step and raw clear
  logic start_prev_ff, step_prev_ff, clr_prev_ff;
  logic start_rise, step_rise, clr_rise;
  assign start_rise = filt[14] & ~start_prev_ff;
  assign step_rise  = filt[13] & ~step_prev_ff;
  assign clr_rise   = user_clear_input & ~clr_prev_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_prev_ff <= 1'b0;
      step_prev_ff  <= 1'b0;
      clr_prev_ff   <= 1'b0;
    end else begin
      start_prev_ff <= filt[14];
      step_prev_ff  <= filt[13];
      clr_prev_ff   <= user_clear_input;
    end
  end

  // aux key pulse checkers, key pressed while low
  logic [1:0] key_raw, key_acc;
  assign key_raw = {aux_key_two_input, aux_key_one_input};
  for (genvar k = 0; k < 2; k++) begin : g_key
    logic [7:0] low_ff, nxt_low;
    logic [4:0] gap_ff, nxt_gap;
    logic       prev_ff, gok_ff, nxt_gok, acc;
    // one driver per accept bit
    assign key_acc[k] = acc;
    always_comb begin
      nxt_low = low_ff;
      nxt_gap = gap_ff;
      nxt_gok = gok_ff;
      acc     = 1'b0;
      if (ms_tick && !key_raw[k] && low_ff != 8'hFF) nxt_low = low_ff + 8'h01;
      if (ms_tick && key_raw[k] && gap_ff != 5'h1F) nxt_gap = gap_ff + 5'h01;
      if (!key_raw[k] && prev_ff) begin
        nxt_low = 8'h00;
        nxt_gok = (gap_ff >= 5'(dio_port_pkg::KEY_MIN_GAP_MS));
      end
      if (key_raw[k] && !prev_ff) begin
        nxt_gap = 5'h00;
        acc = gok_ff && low_ff >= 8'(dio_port_pkg::KEY_MIN_WIDTH_MS)
                     && low_ff <= 8'(dio_port_pkg::KEY_MAX_WIDTH_MS);
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        low_ff  <= 8'h00;
        gap_ff  <= 5'h1F;
        gok_ff  <= 1'b1;
        prev_ff <= 1'b1;
      end else begin
        low_ff  <= nxt_low;
        gap_ff  <= nxt_gap;
        gok_ff  <= nxt_gok;
        prev_ff <= key_raw[k];
      end
    end
    property p_key_width;
      @(posedge aclk) disable iff (!aresetn)
      acc |-> low_ff >= 8'(dio_port_pkg::KEY_MIN_WIDTH_MS)
        && low_ff <= 8'(dio_port_pkg::KEY_MAX_WIDTH_MS) && gok_ff;
    endproperty
    a_key_width: assert property (p_key_width) else $error("key pulse out of limits");
  end

  // axi write and read channels
  logic        awr_ff, wr_ff, bvalid_ff, arr_ff, rvalid_ff;
  logic        aw_hold_ff, w_hold_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] wdata_ff, rdata_ff, rd_word;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic        nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
  logic [7:0]  nxt_waddr;
  logic [31:0] nxt_wdata, nxt_rdata;
  logic [3:0]  nxt_wstrb;
  logic [1:0]  nxt_bresp, nxt_rresp;
  logic        do_wr, wr_hit, rd_hit;
  logic [7:0]  ctrl_q, gpo_q, st_q;
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_waddr   = waddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (s_axi_awvalid && awr_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_ff) begin
      nxt_w_hold = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    do_wr  = aw_hold_ff && w_hold_ff && !bvalid_ff;
    wr_hit = waddr_ff inside {dio_port_pkg::OFF_CTRL, dio_port_pkg::OFF_GPO,
             dio_port_pkg::OFF_STATUS, dio_port_pkg::OFF_IRQ_STAT,
             dio_port_pkg::OFF_IRQ_MASK, dio_port_pkg::OFF_CMD, dio_port_pkg::OFF_INPUTS};
    rd_hit = s_axi_araddr inside {dio_port_pkg::OFF_CTRL, dio_port_pkg::OFF_GPO,
             dio_port_pkg::OFF_STATUS, dio_port_pkg::OFF_IRQ_STAT,
             dio_port_pkg::OFF_IRQ_MASK, dio_port_pkg::OFF_CMD, dio_port_pkg::OFF_INPUTS};
    if (do_wr) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_hit ? dio_port_pkg::RESP_OKAY : dio_port_pkg::RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid && arr_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_hit ? rd_word : 32'h0000_0000;
      nxt_rresp  = rd_hit ? dio_port_pkg::RESP_OKAY : dio_port_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awr_ff     <= 1'b0;
      wr_ff      <= 1'b0;
      arr_ff     <= 1'b0;
      waddr_ff   <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'h0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      awr_ff     <= !nxt_aw_hold && !nxt_bvalid;
      wr_ff      <= !nxt_w_hold && !nxt_bvalid;
      arr_ff     <= !nxt_rvalid;
      waddr_ff   <= nxt_waddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // register file, run state and interrupt
  dio_port_pkg::run_state_e state_ff, nxt_state;
  logic [4:0]  gpo_ff, nxt_gpo;
  logic [7:0]  nxt_filt_ms, code_ff, nxt_code;
  logic [5:0]  ist_ff, nxt_ist, imask_ff, nxt_imask, ev;
  logic [1:0]  src_ff, nxt_src;
  logic        pass_ff, fail_ff, stepm_ff, nxt_pass, nxt_fail, nxt_stepm;
  logic        cmd_ok, cmd_fail, clear_req, trig, pin_low_ff;
  logic        irq_ff, s_oen_ff, f_oen_ff, r_oen_ff;
  always_comb begin
    ctrl_q = filt_ms_ff;
    gpo_q  = {3'h0, gpo_ff};
    st_q   = {2'h0, src_ff, stepm_ff, fail_ff, pass_ff, state_ff == dio_port_pkg::ST_BUSY};
    unique case (s_axi_araddr)
      dio_port_pkg::OFF_CTRL:     rd_word = {24'h00_0000, ctrl_q};
      dio_port_pkg::OFF_GPO:      rd_word = {24'h00_0000, gpo_q};
      dio_port_pkg::OFF_STATUS:   rd_word = {16'h0000, code_ff, st_q};
      dio_port_pkg::OFF_IRQ_STAT: rd_word = {26'h000_0000, ist_ff};
      dio_port_pkg::OFF_IRQ_MASK: rd_word = {26'h000_0000, imask_ff};
      dio_port_pkg::OFF_INPUTS:   rd_word = {10'h000, running_pin_in, failure_pin_in,
                                  success_pin_in, user_clear_input, filt[14:13], sel_f,
                                  3'h0, gpi_f};
      default:                    rd_word = 32'h0000_0000;
    endcase
  end
  always_comb begin
    nxt_filt_ms = filt_ms_ff;
    nxt_gpo     = gpo_ff;
    nxt_imask   = imask_ff;
    nxt_state   = state_ff;
    nxt_code    = code_ff;
    nxt_src     = src_ff;
    nxt_pass    = pass_ff;
    nxt_fail    = fail_ff;
    nxt_stepm   = stepm_ff;
    ev          = 6'h00;
    cmd_ok      = 1'b0;
    cmd_fail    = 1'b0;
    clear_req   = clr_rise;
    if (do_wr && wstrb_ff[0]) begin
      unique case (waddr_ff)
        dio_port_pkg::OFF_CTRL:     nxt_filt_ms = wdata_ff[7:0];
        dio_port_pkg::OFF_GPO:      nxt_gpo = wdata_ff[4:0];
        dio_port_pkg::OFF_IRQ_MASK: nxt_imask = wdata_ff[5:0];
        dio_port_pkg::OFF_CMD: begin
          cmd_ok    = wdata_ff[dio_port_pkg::CMD_OK];
          cmd_fail  = wdata_ff[dio_port_pkg::CMD_FAIL];
          clear_req = clr_rise | wdata_ff[dio_port_pkg::CMD_CLEAR];
        end
        default: ;
      endcase
    end
    ev[dio_port_pkg::EV_START] = start_rise;
    ev[dio_port_pkg::EV_STEP]  = step_rise;
    ev[dio_port_pkg::EV_KEY1]  = key_acc[0];
    ev[dio_port_pkg::EV_KEY2]  = key_acc[1];
    ev[dio_port_pkg::EV_CLEAR] = clear_req;
    trig = start_rise | step_rise | key_acc[0] | key_acc[1];
    if (clear_req) begin
      nxt_state = dio_port_pkg::ST_IDLE;
      nxt_pass  = 1'b0;
      nxt_fail  = 1'b0;
      nxt_stepm = 1'b0;
    end else if (state_ff != dio_port_pkg::ST_BUSY) begin
      if (trig) begin
        nxt_code  = sel_f;
        nxt_pass  = 1'b0;
        nxt_fail  = 1'b0;
        nxt_stepm = step_rise & ~start_rise;
        if (start_rise)      nxt_src = dio_port_pkg::SRC_START;
        else if (step_rise)  nxt_src = dio_port_pkg::SRC_STEP;
        else if (key_acc[0]) nxt_src = dio_port_pkg::SRC_KEY1;
        else                 nxt_src = dio_port_pkg::SRC_KEY2;
        if (sel_f == dio_port_pkg::NO_SCRIPT) begin
          nxt_state = dio_port_pkg::ST_DONE;
          nxt_fail  = 1'b1;
          ev[dio_port_pkg::EV_DONE] = 1'b1;
        end else begin
          nxt_state = dio_port_pkg::ST_BUSY;
        end
      end
    end else if (cmd_ok || cmd_fail) begin
      nxt_state = dio_port_pkg::ST_DONE;
      nxt_pass  = cmd_ok & ~cmd_fail;
      nxt_fail  = cmd_fail;
      ev[dio_port_pkg::EV_DONE] = 1'b1;
    end
    // set wins over write-one clear
    nxt_ist = ist_ff;
    if (do_wr && wstrb_ff[0] && waddr_ff == dio_port_pkg::OFF_IRQ_STAT)
      nxt_ist = ist_ff & ~wdata_ff[5:0];
    nxt_ist = nxt_ist | ev;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_ms_ff <= dio_port_pkg::FILT_MS_RST;
      gpo_ff     <= dio_port_pkg::GPO_RST;
      imask_ff   <= dio_port_pkg::IRQ_MASK_RST;
      ist_ff     <= 6'h00;
      state_ff   <= dio_port_pkg::ST_IDLE;
      code_ff    <= 8'h00;
      src_ff     <= 2'h0;
      pass_ff    <= 1'b0;
      fail_ff    <= 1'b0;
      stepm_ff   <= 1'b0;
      irq_ff     <= 1'b0;
      s_oen_ff   <= 1'b1;
      f_oen_ff   <= 1'b1;
      r_oen_ff   <= 1'b1;
      pin_low_ff <= 1'b0;
    end else begin
      filt_ms_ff <= nxt_filt_ms;
      gpo_ff     <= nxt_gpo;
      imask_ff   <= nxt_imask;
      ist_ff     <= nxt_ist;
      state_ff   <= nxt_state;
      code_ff    <= nxt_code;
      src_ff     <= nxt_src;
      pass_ff    <= nxt_pass;
      fail_ff    <= nxt_fail;
      stepm_ff   <= nxt_stepm;
      irq_ff     <= |(nxt_ist & nxt_imask);
      s_oen_ff   <= ~nxt_pass;
      f_oen_ff   <= ~nxt_fail;
      r_oen_ff   <= nxt_state != dio_port_pkg::ST_BUSY;
      pin_low_ff <= 1'b0;
    end
  end

  // port drive
  assign s_axi_awready    = awr_ff;
  assign s_axi_wready     = wr_ff;
  assign s_axi_bvalid     = bvalid_ff;
  assign s_axi_bresp      = bresp_ff;
  assign s_axi_arready    = arr_ff;
  assign s_axi_rvalid     = rvalid_ff;
  assign s_axi_rdata      = rdata_ff;
  assign s_axi_rresp      = rresp_ff;
  assign general_output   = gpo_ff;
  assign success_pin_out  = pin_low_ff;
  assign failure_pin_out  = pin_low_ff;
  assign running_pin_out  = pin_low_ff;
  assign success_pin_oe_n = s_oen_ff;
  assign failure_pin_oe_n = f_oen_ff;
  assign running_pin_oe_n = r_oen_ff;
  assign irq              = irq_ff;

  // checks
  property p_pass_drive;
    @(posedge aclk) disable iff (!aresetn)
    !success_pin_oe_n |-> state_ff == dio_port_pkg::ST_DONE && !fail_ff;
  endproperty
  a_pass_drive: assert property (p_pass_drive) else $error("success pin driven wrongly");
  property p_fail_drive;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == dio_port_pkg::ST_BUSY && cmd_fail && !clear_req) |=> !failure_pin_oe_n
      && success_pin_oe_n;
  endproperty
  a_fail_drive: assert property (p_fail_drive) else $error("failure pin not driven");
  property p_run_drive;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == dio_port_pkg::ST_BUSY) == !running_pin_oe_n;
  endproperty
  a_run_drive: assert property (p_run_drive) else $error("running pin off its state");
  property p_run_end;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == dio_port_pkg::ST_BUSY && (cmd_ok || cmd_fail)) |=> running_pin_oe_n;
  endproperty
  a_run_end: assert property (p_run_end) else $error("running pin held after end");
  property p_code_latch;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff != dio_port_pkg::ST_BUSY && start_rise && !clear_req) |=> code_ff == $past(sel_f)
      && src_ff == dio_port_pkg::SRC_START;
  endproperty
  a_code_latch: assert property (p_code_latch) else $error("script code not latched");
  property p_zero_code;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff != dio_port_pkg::ST_BUSY && trig && sel_f == 8'h00 && !clear_req) |=> fail_ff
      ##1 !failure_pin_oe_n;
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("code zero did not fail");
  property p_step_event;
    @(posedge aclk) disable iff (!aresetn)
    step_rise |=> ist_ff[dio_port_pkg::EV_STEP];
  endproperty
  a_step_event: assert property (p_step_event) else $error("step edge not recorded");
  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    clr_rise |=> state_ff == dio_port_pkg::ST_IDLE && success_pin_oe_n && failure_pin_oe_n
      && running_pin_oe_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not reset run");
  property p_filter;
    @(posedge aclk) disable iff (!aresetn)
    $changed(filt) |-> $past(ms_tick);
  endproperty
  a_filter: assert property (p_filter) else $error("filtered input moved off tick");
  property p_gpo;
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && wstrb_ff[0] && waddr_ff == dio_port_pkg::OFF_GPO) |=> general_output
      == $past(wdata_ff[4:0]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("general output write lost");
  property p_key_run;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == dio_port_pkg::ST_IDLE && key_acc[0] && !start_rise && !step_rise
      && sel_f != 8'h00 && !clear_req) |=> ##1 !running_pin_oe_n;
  endproperty
  a_key_run: assert property (p_key_run) else $error("key did not start a run");
endmodule
`default_nettype wire

// [tb/fixture_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fixture_model #(
  parameter int MS = 10
) (
  input  wire logic       aclk,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  output wire logic [2:0] pin_level,
  output logic            key_one,
  output logic            key_two
);
  // released open-drain lines float up to the pull-up level
  assign pin_level = pin_oe_n | pin_out;

  // keys idle released
  initial begin
    key_one = 1'b1;
    key_two = 1'b1;
  end

  // hold one key low for whole ms, then release
  task automatic press(input int which, input int ms);
    @(posedge aclk);
    if (which == 1) key_one <= 1'b0;
    else key_two <= 1'b0;
    repeat (ms * MS) @(posedge aclk);
    key_one <= 1'b1;
    key_two <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/programmer_dio_control_port_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected t=%0t got %0h exp %0h", $time, (g), (e)); end end
module programmer_dio_control_port_tb_top;
  localparam int MS = 10;
  localparam logic [7:0] RA [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1C};
  localparam logic [31:0] RD [6] = '{32'h09, 32'h00, 32'h00, 32'h00, 32'h00, 32'h00};
  localparam logic [1:0] RR [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  logic        aclk = 1'b0, aresetn = 1'b0, irq;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, script_select_in = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [4:0]  general_input = 5'h00, general_output;
  logic        step_input = 1'b0, start_input = 1'b0, user_clear_input = 1'b0;
  wire logic   aux_key_one_input, aux_key_two_input;
  wire logic   success_pin_in, failure_pin_in, running_pin_in;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        success_pin_out, success_pin_oe_n, failure_pin_out, failure_pin_oe_n;
  logic        running_pin_out, running_pin_oe_n;
  int          error_cnt = 0, total_checks = 0;

  // 125 MHz clock
  always #4 aclk = ~aclk;

  dio_control_port #(.MS_CYCLES(MS)) dut_u (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .script_select_in, .general_input, .step_input,
    .start_input, .user_clear_input, .aux_key_one_input, .aux_key_two_input,
    .general_output, .success_pin_in, .success_pin_out, .success_pin_oe_n,
    .failure_pin_in, .failure_pin_out, .failure_pin_oe_n, .running_pin_in,
    .running_pin_out, .running_pin_oe_n, .irq);

  fixture_model #(.MS(MS)) fixture_u (.aclk,
    .pin_out({running_pin_out, failure_pin_out, success_pin_out}),
    .pin_oe_n({running_pin_oe_n, failure_pin_oe_n, success_pin_oe_n}),
    .pin_level({running_pin_in, failure_pin_in, success_pin_in}),
    .key_one(aux_key_one_input), .key_two(aux_key_two_input));

  // verdict and end of run
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // axi write, both channels offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    if (!b) begin
      error_cnt++;
      give_verdict();
    end
    `CHK(r, 2'h0)
  endtask

  // axi read into rd, response compared
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    logic ar, h;
    logic [1:0] r;
    h = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !h; n++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      h = s_axi_rvalid;
      rd = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (h) s_axi_rready <= 1'b0;
    end
    if (!h) begin
      error_cnt++;
      give_verdict();
    end
    `CHK(r, er)
  endtask

  // main sequence: reset values, then pin scenarios
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (RA[i]) begin
      axr(RA[i], RR[i]);
      `CHK(rd, RD[i])
    end
    axw(8'h00, 32'h01);
    axw(8'h04, 32'h15);
    `CHK(general_output, 5'h15)
    general_input <= 5'h0A;
    script_select_in <= 8'h05;
    repeat (4 * MS) @(posedge aclk);
    axr(8'h18, 2'h0);
    `CHK(rd[4:0], 5'h0A)
    `CHK(rd[15:8], 8'h05)
    script_select_in <= 8'hFA;
    repeat (MS / 2) @(posedge aclk);
    script_select_in <= 8'h05;
    repeat (4 * MS) @(posedge aclk);
    axr(8'h18, 2'h0);
    `CHK(rd[15:8], 8'h05)
    start_input <= 1'b1;
    repeat (4 * MS) @(posedge aclk);
    `CHK(running_pin_oe_n, 1'b0)
    `CHK(irq, 1'b0)
    axr(8'h08, 2'h0);
    `CHK(rd[15:8], 8'h05)
    axw(8'h10, 32'h3F);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    axw(8'h0C, 32'h3F);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    axw(8'h14, 32'h01);
    repeat (2) @(posedge aclk);
    `CHK(success_pin_oe_n, 1'b0)
    `CHK(running_pin_oe_n, 1'b1)
    axr(8'h18, 2'h0);
    `CHK(rd[21:19], 3'h6)
    axr(8'h0C, 2'h0);
    `CHK(rd, 32'h20)
    start_input <= 1'b0;
    script_select_in <= 8'h00;
    repeat (4 * MS) @(posedge aclk);
    start_input <= 1'b1;
    repeat (4 * MS) @(posedge aclk);
    `CHK(failure_pin_oe_n, 1'b0)
    `CHK(success_pin_oe_n, 1'b1)
    user_clear_input <= 1'b1;
    start_input <= 1'b0;
    script_select_in <= 8'hFF;
    repeat (3) @(posedge aclk);
    `CHK(failure_pin_oe_n, 1'b1)
    user_clear_input <= 1'b0;
    repeat (4 * MS) @(posedge aclk);
    step_input <= 1'b1;
    repeat (4 * MS) @(posedge aclk);
    axr(8'h08, 2'h0);
    `CHK(rd[15:8], 8'hFF)
    `CHK(rd[5:0], 6'h19)
    step_input <= 1'b0;
    axw(8'h14, 32'h03);
    repeat (2) @(posedge aclk);
    `CHK(failure_pin_oe_n, 1'b0)
    `CHK(success_pin_oe_n, 1'b1)
    `CHK(running_pin_oe_n, 1'b1)
    axw(8'h14, 32'h04);
    repeat (2) @(posedge aclk);
    `CHK(running_pin_oe_n, 1'b1)
    `CHK(failure_pin_oe_n, 1'b1)
    for (int k = 1; k <= 2; k++) begin
      fixture_u.press(k, 10);
      repeat (4) @(posedge aclk);
      `CHK(running_pin_oe_n, 1'b1)
      repeat (40 * MS) @(posedge aclk);
      fixture_u.press(k, 50);
      repeat (4) @(posedge aclk);
      `CHK(running_pin_oe_n, 1'b0)
      axr(8'h08, 2'h0);
      `CHK(rd[5:4], 2'(k + 1))
      axw(8'h14, 32'h04);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
